// [verilog/dbi_pkg.sv]
// Shared constants, types and helper functions of the dual-buck slave port.
package dbi_pkg;
	// Fixed upper address bits and the factory bits of each channel.
	localparam logic [3:0] ADDR_FIXED = 4'h7;
	localparam logic [1:0] CH1_FACTORY = 2'h0;
	localparam logic [1:0] CH2_FACTORY = 2'h1;
	localparam logic [7:0] GENERAL_CALL = 8'h00;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam int SCL_MAX_KHZ = 1000;
	localparam int LINK_PERIOD_NS = 64;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SCL_MIN_PERIOD_CYC = (1000000 / SCL_MAX_KHZ) / LINK_PERIOD_NS;
	localparam logic [1:0] GLITCH_CYCLES = 2'h2;
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	localparam int MEM_AW = 9;
	localparam int MEM_DEPTH = 512;
	localparam logic [7:0] REG_RESET = 8'h00;

	typedef struct packed {
		logic chan;
		logic [7:0] addr;
		logic [7:0] data;
	} dbi_wr_type;

	typedef struct packed {
		logic chan;
		logic [7:0] addr;
	} dbi_rq_type;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_PTR = 6'h04,
		ST_DATA = 6'h08,
		ST_TX = 6'h10,
		ST_IGNORE = 6'h20
	} dbi_state_type;

	function automatic logic dbi_addr_hit(input logic [7:0] b,
			input logic [1:0] fac, input logic strap);
		return b[7:1] == {ADDR_FIXED, fac, strap};
	endfunction : dbi_addr_hit

	// Returns the new filtered level and the new disagreement count.
	function automatic logic [2:0] dbi_filt(input logic s, input logic f,
			input logic [1:0] c);
		if (s == f) begin
			return {f, 2'h0};
		end else if (c == GLITCH_CYCLES - 2'h1) begin
			return {s, 2'h0};
		end
		return {f, c + 2'h1};
	endfunction : dbi_filt
endpackage : dbi_pkg

// [verilog/dbi_regmem.sv]
// Byte-wide register store for both channels with registered read data.
module dbi_regmem
	import dbi_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wr_en_in,
	input wire logic [MEM_AW-1:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic rd_en_in,
	input wire logic [MEM_AW-1:0] rd_addr_in,
	output logic [7:0] rd_data_out
);
	logic [7:0] mem_r [MEM_DEPTH];
	logic [MEM_DEPTH-1:0] vld_r;
	logic [7:0] rd_data_r;

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
	end

	// Valid bits let unwritten bytes read as the reset value without the
	// cost of clearing the whole array.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			vld_r <= '0;
		end else if (wr_en_in) begin
			vld_r[wr_addr_in] <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_data_r <= REG_RESET;
		end else if (rd_en_in) begin
			rd_data_r <= vld_r[rd_addr_in] ? mem_r[rd_addr_in] : REG_RESET;
		end
	end

	assign rd_data_out = rd_data_r;
endmodule : dbi_regmem

// [verilog/dbi_slave.sv]
// Two-wire slave port of the dual-buck controller, link and core sides.
// Behaviour
// - Port works with master clock up to 1 MHz; master stays below it.
// - Every byte is 8 bits followed by one acknowledge clock.
// - Data line is input and open-drain output; clock line is input only.
// - Short spikes on both bus inputs are filtered out.
// - One bit per clock; data changes while clock high are conditions.
// - Both lines rest high when the bus is idle.
// - Data falling with clock high is start; data rising is stop.
// - A repeated start keeps the bus busy and restarts the transaction.
// - Stop is seen anywhere, except in the same clock high as a start.
// - The device never holds the clock low.
// - The all-zeros general call address gets no acknowledge.
// - Address is 0111, two factory bits, then the strap bit.
// - Each channel answers at its own distinct address.
// - First byte holds seven address bits then the direction bit.
// - Direction 1 reads from the device, 0 writes to it.
// - Device pulls data low through the ninth clock of received bytes.
// - Write frame: start, address write, pointer, data, stop.
// - Read frame: write pointer, repeated start, address read, data, stop.
// - Single register write follows the write-byte sequence exactly.
// - Written byte lands only at the next data rising edge after acknowledge.
// - Any number of pointer and data pairs accepted until stop.
module dbi_slave
	import dbi_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic link_clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic strap_id_bit_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	output logic wr_valid_out,
	output dbi_wr_type wr_info_out
);
	logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r, strap_s1_r, strap_s2_r;
	logic scl_f_r, sda_f_r, scl_p_r, sda_p_r;
	logic [1:0] scl_c_r, sda_c_r;
	logic scl_rise, scl_fall, sda_rise, start_det, stop_det;
	logic byte_done, ack_enter, slot_end, ack_rise, tx_load;
	logic start_hi_r, strap_taken_r, strap_id_r;
	logic [2:0] strap_cnt_r;
	logic [3:0] bitcnt_r;
	logic [7:0] shift_r, rx_byte, ptr_r, tx_r, rd_byte_r;
	logic rw_bit, hit1, hit2, addr_hit, chan_r;
	dbi_state_type state_r;
	logic ack_due_r, tx_data_r, sda_oe_n_r, sda_lvl_r;
	logic pend_r, armed_r, wr_tgl_r, rq_tgl_r;
	dbi_wr_type pend_w_r, wr_word_r;
	dbi_rq_type rq_word_r;
	logic rd_s1_r, rd_s2_r, rd_s3_r;
	logic wr_s1_r, wr_s2_r, wr_s3_r, rq_s1_r, rq_s2_r, rq_s3_r;
	logic wr_edge, rq_edge, rd_pend_r, rd_tgl_r, wr_valid_r;
	logic [7:0] rd_hold_r, mem_rdata;
	dbi_wr_type wr_info_r;

	// The clock pin is only ever sampled; the port has no clock output.
	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			strap_s1_r <= 1'b0;
			strap_s2_r <= 1'b0;
		end else begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			strap_s1_r <= strap_id_bit_in;
			strap_s2_r <= strap_s1_r;
		end
	end

	// Filtered levels reset high, matching an idle bus.
	// Two link cycles of delay stay far below the shortest clock phase.
	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
			scl_c_r <= 2'h0;
			sda_c_r <= 2'h0;
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end else begin
			{scl_f_r, scl_c_r} <= dbi_filt(scl_s2_r, scl_f_r, scl_c_r);
			{sda_f_r, sda_c_r} <= dbi_filt(sda_s2_r, sda_f_r, sda_c_r);
			scl_p_r <= scl_f_r;
			sda_p_r <= sda_f_r;
		end
	end

	assign scl_rise = scl_f_r && !scl_p_r;
	assign scl_fall = !scl_f_r && scl_p_r;
	assign sda_rise = sda_f_r && !sda_p_r;
	assign start_det = scl_f_r && scl_p_r && sda_p_r && !sda_f_r;
	assign stop_det = scl_f_r && scl_p_r && !sda_p_r && sda_f_r &&
		!start_hi_r;
	assign rx_byte = {shift_r[6:0], sda_f_r};
	assign rw_bit = rx_byte[0];
	assign byte_done = scl_rise && bitcnt_r == LAST_DATA_BIT;
	assign ack_enter = scl_fall && !start_hi_r && bitcnt_r == LAST_DATA_BIT;
	assign slot_end = scl_fall && !start_hi_r && bitcnt_r == ACK_BIT;
	assign ack_rise = scl_rise && bitcnt_r == ACK_BIT;
	assign tx_load = slot_end && state_r == ST_TX;

	// The strap is taken once after reset release and then frozen.
	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			strap_cnt_r <= 3'h0;
			strap_taken_r <= 1'b0;
			strap_id_r <= 1'b0;
		end else if (!strap_taken_r) begin
			if (strap_cnt_r == STRAP_SETTLE) begin
				strap_taken_r <= 1'b1;
				strap_id_r <= strap_s2_r;
			end else begin
				strap_cnt_r <= strap_cnt_r + 3'h1;
			end
		end
	end

	assign hit1 = strap_taken_r &&
		dbi_addr_hit(rx_byte, CH1_FACTORY, strap_id_r);
	assign hit2 = strap_taken_r &&
		dbi_addr_hit(rx_byte, CH2_FACTORY, strap_id_r);
	assign addr_hit = (hit1 || hit2) && rx_byte != GENERAL_CALL;

	// Marks the clock-high interval that holds a start, so a stop in the
	// same interval is ignored and the start's own clock fall is skipped.
	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			start_hi_r <= 1'b0;
		end else if (start_det) begin
			start_hi_r <= 1'b1;
		end else if (scl_fall) begin
			start_hi_r <= 1'b0;
		end
	end

	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bitcnt_r <= 4'h0;
			shift_r <= 8'h00;
		end else if (start_det || stop_det) begin
			bitcnt_r <= 4'h0;
		end else begin
			if (scl_rise && bitcnt_r <= LAST_DATA_BIT) begin
				shift_r <= rx_byte;
			end
			if (scl_fall && !start_hi_r) begin
				bitcnt_r <= (bitcnt_r == ACK_BIT) ? 4'h0 : bitcnt_r + 4'h1;
			end
		end
	end

	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= ST_IDLE;
			chan_r <= 1'b0;
			ptr_r <= 8'h00;
		end else if (start_det) begin
			state_r <= ST_ADDR;
		end else if (stop_det) begin
			state_r <= ST_IDLE;
		end else if (byte_done) begin
			unique case (state_r)
				ST_ADDR: begin
					if (addr_hit) begin
						chan_r <= hit2;
						state_r <= rw_bit ? ST_TX : ST_PTR;
					end else begin
						state_r <= ST_IGNORE;
					end
				end
				ST_PTR: begin
					ptr_r <= rx_byte;
					state_r <= ST_DATA;
				end
				ST_DATA: begin
					state_r <= ST_PTR;
				end
				ST_IDLE, ST_TX, ST_IGNORE: begin
					state_r <= state_r;
				end
			endcase
		end else if (ack_rise && state_r == ST_TX && sda_f_r) begin
			state_r <= ST_IGNORE;
		end else if (tx_load) begin
			ptr_r <= ptr_r + 8'h1;
		end
	end

	// Open-drain data: the level is always low and only the enable moves.
	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_due_r <= 1'b0;
			tx_data_r <= 1'b0;
			tx_r <= 8'h00;
			sda_oe_n_r <= 1'b1;
		end else if (start_det || stop_det) begin
			tx_data_r <= 1'b0;
			sda_oe_n_r <= 1'b1;
		end else begin
			if (byte_done) begin
				ack_due_r <= (state_r == ST_ADDR && addr_hit) ||
					state_r == ST_PTR || state_r == ST_DATA;
			end
			if (ack_enter) begin
				tx_data_r <= 1'b0;
				sda_oe_n_r <= !ack_due_r;
			end else if (tx_load) begin
				tx_data_r <= 1'b1;
				tx_r <= {rd_byte_r[6:0], 1'b0};
				sda_oe_n_r <= rd_byte_r[7];
			end else if (slot_end) begin
				sda_oe_n_r <= 1'b1;
			end else if (scl_fall && tx_data_r) begin
				tx_r <= {tx_r[6:0], 1'b0};
				sda_oe_n_r <= tx_r[7];
			end
		end
	end

	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sda_lvl_r <= 1'b0;
		end else begin
			sda_lvl_r <= 1'b0;
		end
	end

	// A data byte waits for the first rising data edge after its
	// acknowledge slot; only then is the word handed to the core side.
	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pend_r <= 1'b0;
			armed_r <= 1'b0;
			pend_w_r <= '0;
			wr_word_r <= '0;
			wr_tgl_r <= 1'b0;
		end else if (byte_done && state_r == ST_DATA) begin
			pend_w_r <= {chan_r, ptr_r, rx_byte};
			pend_r <= 1'b1;
			armed_r <= 1'b0;
		end else if (slot_end && pend_r) begin
			armed_r <= 1'b1;
		end else if (armed_r && sda_rise) begin
			wr_word_r <= pend_w_r;
			wr_tgl_r <= !wr_tgl_r;
			pend_r <= 1'b0;
			armed_r <= 1'b0;
		end
	end

	// Reads are fetched one byte ahead so the core round trip fits well
	// inside a byte time even at the top clock rate.
	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rq_word_r <= '0;
			rq_tgl_r <= 1'b0;
		end else if (byte_done && state_r == ST_ADDR && addr_hit && rw_bit) begin
			rq_word_r <= {hit2, ptr_r};
			rq_tgl_r <= !rq_tgl_r;
		end else if (tx_load) begin
			rq_word_r <= {chan_r, ptr_r + 8'h1};
			rq_tgl_r <= !rq_tgl_r;
		end
	end

	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_s1_r <= 1'b0;
			rd_s2_r <= 1'b0;
			rd_s3_r <= 1'b0;
			rd_byte_r <= REG_RESET;
		end else begin
			rd_s1_r <= rd_tgl_r;
			rd_s2_r <= rd_s1_r;
			rd_s3_r <= rd_s2_r;
			if (rd_s2_r != rd_s3_r) begin
				rd_byte_r <= rd_hold_r;
			end
		end
	end

	assign sda_out = sda_lvl_r;
	assign sda_oe_n_out = sda_oe_n_r;

	// Core side: toggles come over two flip-flops, the held words are
	// stable by the time the synchronised toggle is seen.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_s1_r <= 1'b0;
			wr_s2_r <= 1'b0;
			wr_s3_r <= 1'b0;
			rq_s1_r <= 1'b0;
			rq_s2_r <= 1'b0;
			rq_s3_r <= 1'b0;
		end else begin
			wr_s1_r <= wr_tgl_r;
			wr_s2_r <= wr_s1_r;
			wr_s3_r <= wr_s2_r;
			rq_s1_r <= rq_tgl_r;
			rq_s2_r <= rq_s1_r;
			rq_s3_r <= rq_s2_r;
		end
	end

	assign wr_edge = wr_s2_r != wr_s3_r;
	assign rq_edge = rq_s2_r != rq_s3_r;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_valid_r <= 1'b0;
			wr_info_r <= '0;
		end else begin
			wr_valid_r <= wr_edge;
			if (wr_edge) begin
				wr_info_r <= wr_word_r;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_pend_r <= 1'b0;
			rd_hold_r <= REG_RESET;
			rd_tgl_r <= 1'b0;
		end else begin
			rd_pend_r <= rq_edge;
			if (rd_pend_r) begin
				rd_hold_r <= mem_rdata;
				rd_tgl_r <= !rd_tgl_r;
			end
		end
	end

	dbi_regmem u_mem (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.wr_en_in(wr_edge),
		.wr_addr_in({wr_word_r.chan, wr_word_r.addr}),
		.wr_data_in(wr_word_r.data),
		.rd_en_in(rq_edge),
		.rd_addr_in({rq_word_r.chan, rq_word_r.addr}),
		.rd_data_out(mem_rdata)
	);

	assign wr_valid_out = wr_valid_r;
	assign wr_info_out = wr_info_r;

	sequence s_addr_hit;
		byte_done && state_r == ST_ADDR && addr_hit;
	endsequence

	sequence s_high_hold;
		scl_f_r && scl_p_r && !$past(start_det) && !$past(stop_det);
	endsequence

	property p_glitch;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		$changed(scl_f_r) |-> $past(scl_s2_r) == scl_f_r &&
			$past(scl_s2_r, 2) == scl_f_r;
	endproperty
	a_glitch: assert property (p_glitch) else $error("spike passed filter");

	property p_start;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		start_det |=> state_r == ST_ADDR && bitcnt_r == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_stop;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		stop_det |=> state_r == ST_IDLE && sda_oe_n_r;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");

	property p_gc;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		(byte_done && state_r == ST_ADDR && rx_byte == GENERAL_CALL) |=>
			state_r == ST_IGNORE;
	endproperty
	a_gc: assert property (p_gc) else $error("general call accepted");

	property p_quiet;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		state_r == ST_IGNORE |-> sda_oe_n_r;
	endproperty
	a_quiet: assert property (p_quiet) else $error("drive when ignored");

	property p_ack_hold;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		(bitcnt_r == ACK_BIT && scl_f_r && scl_p_r && ack_due_r) |->
			!sda_oe_n_r;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack lost");

	property p_route;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		s_addr_hit |=> chan_r == $past(hit2) &&
			state_r == ($past(rw_bit) ? ST_TX : ST_PTR);
	endproperty
	a_route: assert property (p_route) else $error("bad routing");

	property p_stable_hi;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		s_high_hold |-> $stable(sda_oe_n_r);
	endproperty
	a_stable_hi: assert property (p_stable_hi) else $error("sda moved");

	property p_commit;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		$changed(wr_tgl_r) |-> $past(armed_r) && $past(sda_rise);
	endproperty
	a_commit: assert property (p_commit) else $error("early commit");

	property p_core_wr;
		@(posedge clk_in) disable iff (!reset_n_in)
		wr_edge |=> wr_valid_r && wr_info_r == $past(wr_word_r);
	endproperty
	a_core_wr: assert property (p_core_wr) else $error("write lost");
endmodule : dbi_slave

// [sim/dbi_master.sv]
// Behavioural two-wire bus master that drives the slave port.
module dbi_master (
	output logic scl_out,
	output logic sda_out,
	input wire logic sda_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// A quarter bit of 320 ns gives a 1280 ns bit, under the clock ceiling.
	localparam int QTR_NS = 320;
	logic glitch_en;

	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
		glitch_en = 1'b0;
	end

	// Also serves as a repeated start when entered with the clock low.
	task automatic start_cond;
		#QTR_NS sda_out = 1'b1;
		#QTR_NS scl_out = 1'b1;
		#QTR_NS sda_out = 1'b0;
		#QTR_NS scl_out = 1'b0;
	endtask : start_cond

	// Start and stop inside one clock-high interval; the stop must not count.
	task automatic start_blip;
		#QTR_NS scl_out = 1'b1;
		#QTR_NS sda_out = 1'b0;
		#QTR_NS sda_out = 1'b1;
		#QTR_NS scl_out = 1'b0;
	endtask : start_blip

	task automatic stop_cond;
		#QTR_NS sda_out = 1'b0;
		#QTR_NS scl_out = 1'b1;
		#QTR_NS sda_out = 1'b1;
		#QTR_NS;
	endtask : stop_cond

	// Data only moves while the clock is low.
	task automatic bit_io(input logic b, output logic seen);
		#QTR_NS sda_out = b;
		if (glitch_en) begin
			// A spike shorter than one link cycle must be swallowed.
			#64 scl_out = 1'b1;
			#32 scl_out = 1'b0;
			#(QTR_NS - 96) scl_out = 1'b1;
		end else begin
			#QTR_NS scl_out = 1'b1;
		end
		#QTR_NS seen = sda_in;
		#QTR_NS scl_out = 1'b0;
	endtask : bit_io

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic ack_it, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(~ack_it, s);
	endtask : recv_byte
endmodule : dbi_master

// [sim/dbi_slave_bench.sv]
// Self-checking bench of the dual-buck slave port with a bus master model.
`define CHK(what, exp, got) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("[FAIL] %s expected %h seen %h", what, exp, got); \
	end \
end

module dbi_slave_bench
	import dbi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, reset_n_in, link_clk_in, strap_id_bit_in;
	logic mst_scl, mst_sda, sda_out, sda_oe_n_out, wr_valid_out;
	logic sda_line;
	dbi_wr_type wr_info_out;
	dbi_wr_type wr_q[$];
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;

	// The pull-up wins whenever nobody pulls the data line low.
	assign sda_line = mst_sda & (sda_oe_n_out ? 1'b1 : sda_out);

	dbi_slave dut (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.link_clk_in(link_clk_in),
		.scl_in(mst_scl),
		.sda_in(sda_line),
		.strap_id_bit_in(strap_id_bit_in),
		.sda_out(sda_out),
		.sda_oe_n_out(sda_oe_n_out),
		.wr_valid_out(wr_valid_out),
		.wr_info_out(wr_info_out)
	);

	dbi_master mst (
		.scl_out(mst_scl),
		.sda_out(mst_sda),
		.sda_in(sda_line)
	);

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	initial begin
		link_clk_in = 1'b0;
		#13;
		forever #32 link_clk_in = ~link_clk_in;
	end

	// Sampled on the falling edge so the registered outputs have settled.
	always @(negedge clk_in) begin
		if (wr_valid_out === 1'b1) begin
			wr_q.push_back(wr_info_out);
		end
		cycles++;
		if (cycles == 96000) begin
			fails++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	function automatic logic [7:0] adr_of(input logic ch, input logic st,
			input logic rd);
		return {ADDR_FIXED, ch ? CH2_FACTORY : CH1_FACTORY, st, rd};
	endfunction : adr_of

	// Reset is held for two link cycles since that clock is the slower one.
	task automatic do_reset(input logic st);
		strap_id_bit_in = st;
		reset_n_in = 1'b0;
		repeat (2) @(posedge link_clk_in);
		@(negedge clk_in) reset_n_in = 1'b1;
		repeat (16) @(posedge link_clk_in);
		@(negedge clk_in);
	endtask : do_reset

	task automatic settle;
		repeat (250) @(negedge clk_in);
	endtask : settle

	task automatic chk_ack(input logic [7:0] b, input logic exp);
		logic a;
		mst.send_byte(b, a);
		`CHK("ack", exp, a)
	endtask : chk_ack

	task automatic open_frame(input logic [7:0] adr, input logic exp);
		mst.start_cond();
		chk_ack(adr, exp);
	endtask : open_frame

	task automatic chk_write(input logic ch, input logic [7:0] p,
			input logic [7:0] d);
		dbi_wr_type w;
		`CHK("write count", 1'b1, wr_q.size() > 0)
		if (wr_q.size() > 0) begin
			w = wr_q.pop_front();
			`CHK("write", {ch, p, d}, w)
		end
	endtask : chk_write

	task automatic t_reset;
		do_reset(1'b0);
		`CHK("idle oe_n", 1'b1, sda_oe_n_out)
		`CHK("valid", 1'b0, wr_valid_out)
		`CHK("info", 17'h0, wr_info_out)
	endtask : t_reset

	task automatic t_write_single;
		open_frame(adr_of(1'b0, 1'b0, 1'b0), 1'b1);
		chk_ack(8'h05, 1'b1);
		chk_ack(8'ha5, 1'b1);
		`CHK("early write", 0, wr_q.size())
		mst.stop_cond();
		settle();
		chk_write(1'b0, 8'h05, 8'ha5);
		`CHK("idle oe_n", 1'b1, sda_oe_n_out)
	endtask : t_write_single

	task automatic t_pairs_glitch;
		mst.glitch_en = 1'b1;
		open_frame(adr_of(1'b1, 1'b0, 1'b0), 1'b1);
		chk_ack(8'h05, 1'b1);
		chk_ack(8'h3c, 1'b1);
		chk_ack(8'hff, 1'b1);
		chk_ack(8'h81, 1'b1);
		mst.stop_cond();
		mst.glitch_en = 1'b0;
		settle();
		chk_write(1'b1, 8'h05, 8'h3c);
		chk_write(1'b1, 8'hff, 8'h81);
	endtask : t_pairs_glitch

	task automatic t_read(input logic ch, input logic [7:0] exp);
		logic [7:0] d;
		open_frame(adr_of(ch, 1'b0, 1'b0), 1'b1);
		chk_ack(8'h05, 1'b1);
		open_frame(adr_of(ch, 1'b0, 1'b1), 1'b1);
		mst.recv_byte(1'b1, d);
		`CHK("read data", exp, d)
		mst.recv_byte(1'b0, d);
		mst.stop_cond();
		`CHK("next read", REG_RESET, d)
	endtask : t_read

	// A stop in the start's own clock-high is ignored; a stop in mid-byte
	// ends the frame with nothing written.
	task automatic t_refused;
		logic s;
		mst.start_blip();
		chk_ack(adr_of(1'b0, 1'b0, 1'b0), 1'b1);
		chk_ack(8'h07, 1'b1);
		mst.bit_io(1'b0, s);
		mst.stop_cond();
		open_frame(GENERAL_CALL, 1'b0);
		mst.stop_cond();
		settle();
		`CHK("stray write", 0, wr_q.size())
	endtask : t_refused

	task automatic t_strap;
		do_reset(1'b1);
		open_frame(adr_of(1'b0, 1'b0, 1'b0), 1'b0);
		mst.stop_cond();
		open_frame(adr_of(1'b0, 1'b1, 1'b0), 1'b1);
		chk_ack(8'h10, 1'b1);
		chk_ack(8'h5a, 1'b1);
		mst.stop_cond();
		settle();
		chk_write(1'b0, 8'h10, 8'h5a);
		`CHK("stray write", 0, wr_q.size())
	endtask : t_strap

	initial begin
		reset_n_in = 1'b0;
		strap_id_bit_in = 1'b0;
		@(negedge clk_in);
		t_reset();
		t_write_single();
		t_pairs_glitch();
		t_read(1'b0, 8'ha5);
		t_read(1'b1, 8'h3c);
		t_refused();
		t_strap();
		wrap_up();
	end
endmodule : dbi_slave_bench
